/* File: rtl/sfsp_protect.sv */
// Sector protection: SPI command decode, protection map, hardware pin and access check
//
// Operation
// - Low write-protect pin blocks map changes and protected sector changes.
// - Pin low enables protection; release drops it unless software enabled.
// - Software enable survives pin release; only disable with pin high or power-up clears.
// - Disable command ignored while write-protect pin is low.
// - Pin overrides software state only for guarding sectors.
// - Write-protect input is glitch filtered.
// - Sixteen-byte map, byte n guards sector n.
// - Map must be erased before reprogramming; host issues erase first.
// - Sectors 1-15: FFh protected, 00h unprotected.
// - Byte 0 bits 7:6 guard sub-sector 0a, bits 5:4 guard 0b.
// - Map reads 00h everywhere as shipped.
// - Erase command starts timed map erase at select rise, busy shown.
// - Map erase sets every byte to FFh.
// - Map erase accepted with protection enabled or disabled.
// - Program command takes sixteen bytes, timed program, busy shown.
// - Extra program bytes wrap the index to location zero.
// - Map program accepted with protection enabled or disabled.
// - Program data staged through the first data buffer, overwriting it.
// - Map contents not guaranteed if power fails mid-cycle.
// - Enable command at select rise turns on software protection.
// - Disable command at select rise turns it off when pin high.
// - Software protection state is cleared on power-up.
`default_nettype none
module sfsp_protect
    import sfsp_pkg::*;
#(
    parameter int ERASE_CYC = SFSP_ERASE_CYC,
    parameter int PROG_CYC = SFSP_PROG_CYC,
    parameter int FILT_CYC = SFSP_WP_FILT_CYC,
    parameter int BUF_BYTES = 528
)(
    input wire logic clk,
    input wire logic reset,
    input wire sfsp_spi_t spi,
    input wire logic wp_n,
    input wire sfsp_req_t req,
    output logic req_allow,
    output logic busy,
    output logic prot_enabled,
    output logic sw_prot_q,
    output logic map_locked,
    output logic [SFSP_MAP_BYTES*8-1:0] map_bits
);
    typedef enum {
        SFSP_IDLE,
        SFSP_ERASE,
        SFSP_PROG
    } sfsp_state_t;

    logic [2:0] pins;
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    logic wp_sync_n;
    logic wp_filt_n;
    logic sck_prev_q;
    logic cs_prev_q;
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] byte_cnt_q;
    logic [7:0] op_q;
    logic prefix_ok_q;
    logic [SFSP_IDX_W-1:0] wr_idx_q;
    logic [7:0] map_q [SFSP_MAP_BYTES];
    logic [7:0] buf1_q [BUF_BYTES];
    logic [7:0] byte_now;
    logic byte_done;
    sfsp_state_t state_q;
    logic [SFSP_TIMER_W-1:0] timer_q;
    logic cmd_ok;
    logic sector_guard;
    logic cmd_end;
    logic four_bytes;
    logic prog_take;

    // All link pins and the protect pin cross through three synchroniser flops and a registered agreement output
    sfsp_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .din({spi.cs_n, spi.sck, spi.si}),
        .dout(pins)
    );

    sfsp_sync #(
        .WIDTH(1)
    ) u_wp_sync (
        .clk(clk),
        .reset(reset),
        .din(wp_n),
        .dout(wp_sync_n)
    );

    sfsp_wp_filter #(
        .FILT_CYC(FILT_CYC)
    ) u_wp_filter (
        .clk(clk),
        .reset(reset),
        .wp_sync_n(wp_sync_n),
        .wp_filt_n(wp_filt_n)
    );

    assign cs_n_s = pins[2];
    assign sck_s = pins[1];
    assign si_s = pins[0];

    // Edge detection on the resolved pin levels
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            // Matches the synchroniser's reset level, so no false edge follows reset
            sck_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end
        else
        begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
        end
    end

    assign sck_rise = sck_s && !sck_prev_q && !cs_n_s;
    assign cs_rise = cs_n_s && !cs_prev_q;
    assign cs_fall = !cs_n_s && cs_prev_q;
    assign byte_now = {shift_q[6:0], si_s};
    assign byte_done = sck_rise && (bit_cnt_q == 3'd7);

    // Byte assembly, MSB first; SPI modes 0 and 3 both sample on the rise
    always_ff @(posedge clk)
    begin
        if (reset || cs_fall)
        begin
            shift_q <= '0;
            bit_cnt_q <= '0;
        end
        else if (sck_rise)
        begin
            shift_q <= byte_now;
            bit_cnt_q <= bit_cnt_q + 3'd1;
        end
    end

    // Prefix check and opcode capture
    always_ff @(posedge clk)
    begin
        if (reset || cs_fall)
        begin
            byte_cnt_q <= '0;
            op_q <= '0;
            prefix_ok_q <= 1'b1;
        end
        else if (byte_done)
        begin
            if (byte_cnt_q != 8'hff)
                byte_cnt_q <= byte_cnt_q + 8'd1;
            unique case (byte_cnt_q)
                8'd0: prefix_ok_q <= prefix_ok_q && (byte_now == SFSP_PRE0);
                8'd1: prefix_ok_q <= prefix_ok_q && (byte_now == SFSP_PRE1);
                8'd2: prefix_ok_q <= prefix_ok_q && (byte_now == SFSP_PRE2);
                8'd3: op_q <= byte_now;
                default: op_q <= op_q;
            endcase
        end
    end

    // Command is good only on a byte boundary after the four opcode bytes (data may follow)
    assign cmd_ok = prefix_ok_q && (byte_cnt_q >= 8'd4) && (bit_cnt_q == 3'd0)
        && (state_q == SFSP_IDLE);

    // Commands act on the select rise; most take no data after the opcode
    assign four_bytes = (byte_cnt_q == 8'd4);
    assign cmd_end = cs_rise && cmd_ok;

    // Data bytes after the opcode of a program command
    assign prog_take = byte_done && (byte_cnt_q >= 8'd4) && prefix_ok_q
        && (op_q == SFSP_OP_PROG);

    // Program data staging through the first data buffer
    always_ff @(posedge clk)
    begin
        if (reset || cs_fall)
            wr_idx_q <= '0;
        else if (prog_take)
        begin
            buf1_q[wr_idx_q] <= byte_now;
            wr_idx_q <= wr_idx_q + 1'b1;
        end
    end

    // Map is locked while the filtered pin is low
    assign map_locked = !wp_filt_n;

    // Self-timed map erase and program
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= SFSP_IDLE;
            timer_q <= '0;
        end
        else
        begin
            // Cycles start only from idle, so commands during a cycle are dropped
            unique case (state_q)
                SFSP_IDLE:
                begin
                    if (cmd_end && !map_locked && four_bytes
                        && op_q == SFSP_OP_ERASE)
                    begin
                        state_q <= SFSP_ERASE;
                        timer_q <= SFSP_TIMER_W'(ERASE_CYC - 1);
                    end
                    else if (cmd_end && !map_locked
                        && op_q == SFSP_OP_PROG)
                    begin
                        state_q <= SFSP_PROG;
                        timer_q <= SFSP_TIMER_W'(PROG_CYC - 1);
                    end
                end
                SFSP_ERASE, SFSP_PROG:
                begin
                    if (timer_q == '0)
                        state_q <= SFSP_IDLE;
                    else
                        timer_q <= timer_q - 1'b1;
                end
            endcase
        end
    end

    assign busy = (state_q != SFSP_IDLE);

    // Nonvolatile map; reset stands for the as-shipped contents
    // Written only when a timed cycle ends; a reset mid-cycle reloads the as-shipped contents
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < SFSP_MAP_BYTES; i++)
                map_q[i] <= SFSP_MAP_RESET;
        end
        else if (state_q == SFSP_ERASE && timer_q == '0)
        begin
            for (int i = 0; i < SFSP_MAP_BYTES; i++)
                map_q[i] <= SFSP_BYTE_PROT;
        end
        else if (state_q == SFSP_PROG && timer_q == '0)
        begin
            // Programming only clears bits, so an unerased map keeps its zeros
            for (int i = 0; i < SFSP_MAP_BYTES; i++)
                map_q[i] <= map_q[i] & buf1_q[i];
        end
    end

    // Software enable state, volatile
    always_ff @(posedge clk)
    begin
        if (reset)
            sw_prot_q <= 1'b0;
        else if (cmd_end && four_bytes && op_q == SFSP_OP_ENABLE)
            sw_prot_q <= 1'b1;
        else if (cmd_end && four_bytes && op_q == SFSP_OP_DISABLE
            && wp_filt_n)
            sw_prot_q <= 1'b0;
    end

    // Pin forces protection on but never touches the software state
    assign prot_enabled = sw_prot_q || !wp_filt_n;

    // Sector guard lookup
    always_comb
    begin
        if (req.sector == '0)
        begin
            if (req.page < 8'd8)
                sector_guard = &map_q[0][SFSP_SUB0A_HI:SFSP_SUB0A_LO];
            else
                sector_guard = &map_q[0][SFSP_SUB0B_HI:SFSP_SUB0B_LO];
        end
        else
            sector_guard = (map_q[req.sector] == SFSP_BYTE_PROT);
    end

    assign req_allow = req.valid && !(prot_enabled && sector_guard);

    generate
        for (genvar g = 0; g < SFSP_MAP_BYTES; g++)
        begin : g_map_out
            assign map_bits[g*8 +: 8] = map_q[g];
        end
    endgenerate
endmodule // sfsp_protect
`default_nettype wire

/* File: rtl/sfsp_pkg.sv */
// Package: constants and types of the serial flash sector protection block
`default_nettype none
package sfsp_pkg;
    localparam int SFSP_MAP_BYTES = 16;
    localparam int SFSP_IDX_W = 4;
    localparam int SFSP_CLK_MHZ = 100;
    // Command prefix and fourth bytes
    localparam logic [7:0] SFSP_PRE0 = 8'h3d;
    localparam logic [7:0] SFSP_PRE1 = 8'h2a;
    localparam logic [7:0] SFSP_PRE2 = 8'h7f;
    localparam logic [7:0] SFSP_OP_ERASE = 8'hcf;
    localparam logic [7:0] SFSP_OP_PROG = 8'hfc;
    localparam logic [7:0] SFSP_OP_ENABLE = 8'ha9;
    localparam logic [7:0] SFSP_OP_DISABLE = 8'h9a;
    // Map byte encodings
    localparam logic [7:0] SFSP_BYTE_PROT = 8'hff;
    localparam logic [7:0] SFSP_BYTE_UNPROT = 8'h00;
    localparam logic [7:0] SFSP_MAP_RESET = 8'h00;
    localparam int SFSP_SUB0A_HI = 7;
    localparam int SFSP_SUB0A_LO = 6;
    localparam int SFSP_SUB0B_HI = 5;
    localparam int SFSP_SUB0B_LO = 4;
    // Timing, in microseconds, and derived cycle counts (longest times round down)
    localparam int SFSP_MAP_ERASE_TIME_US = 20;
    localparam int SFSP_PAGE_PROGRAM_TIME_US = 10;
    localparam int SFSP_HW_PROTECT_ENABLE_DELAY_US = 1;
    localparam int SFSP_HW_PROTECT_DISABLE_DELAY_US = 1;
    localparam int SFSP_ERASE_CYC = SFSP_MAP_ERASE_TIME_US * SFSP_CLK_MHZ;
    localparam int SFSP_PROG_CYC = SFSP_PAGE_PROGRAM_TIME_US * SFSP_CLK_MHZ;
    localparam int SFSP_WP_FILT_CYC = SFSP_HW_PROTECT_ENABLE_DELAY_US * SFSP_CLK_MHZ / 2;
    localparam int SFSP_TIMER_W = 16;
    localparam int SFSP_FILT_W = 8;
    // Array access request from the memory core
    typedef struct packed {
        logic valid;
        logic [3:0] sector;
        logic [7:0] page;
    } sfsp_req_t;
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sfsp_spi_t;
endpackage
`default_nettype wire

/* File: rtl/sfsp_sync.sv */
// Three-stage pin synchroniser with agreement detect
`default_nettype none
module sfsp_sync
    import sfsp_pkg::*;
#(
    parameter int WIDTH = 3
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes once the second and third stages agree
    always_ff @(posedge clk)
    begin
        if (reset)
            dout <= '1;
        else
        begin
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_q[i] == s3_q[i])
                    dout[i] <= s3_q[i];
            end
        end
    end
endmodule // sfsp_sync
`default_nettype wire

/* File: rtl/sfsp_wp_filter.sv */
// Glitch filter for the active-low write-protect pin
`default_nettype none
module sfsp_wp_filter
    import sfsp_pkg::*;
#(
    parameter int FILT_CYC = SFSP_WP_FILT_CYC
)(
    input wire logic clk,
    input wire logic reset,
    input wire logic wp_sync_n,
    output logic wp_filt_n
);
    logic [SFSP_FILT_W-1:0] cnt_q;

    // Level must hold steady FILT_CYC cycles before it is accepted
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            wp_filt_n <= 1'b1;
        end
        else if (wp_sync_n == wp_filt_n)
            cnt_q <= '0;
        else if (cnt_q == SFSP_FILT_W'(FILT_CYC - 1))
        begin
            cnt_q <= '0;
            wp_filt_n <= wp_sync_n;
        end
        else
            cnt_q <= cnt_q + 1'b1;
    end
endmodule // sfsp_wp_filter
`default_nettype wire

/* File: verification/sfsp_protect_properties.sv */
// Checker for the sector protection block ports
`default_nettype none
module sfsp_protect_properties
    import sfsp_pkg::*;
#(
    parameter int ERASE_CYC = SFSP_ERASE_CYC
)(
    input wire logic clk,
    input wire logic reset,
    input wire sfsp_req_t req,
    input wire logic req_allow,
    input wire logic busy,
    input wire logic prot_enabled,
    input wire logic sw_prot_q,
    input wire logic map_locked,
    input wire logic [SFSP_MAP_BYTES*8-1:0] map_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAX_BUSY = ERASE_CYC + 2;
    int busy_run_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Counts the cycles of the running map cycle; too long for a delay range
    always_ff @(posedge clk)
    begin
        if (reset || !busy)
            busy_run_q <= 0;
        else
            busy_run_q <= busy_run_q + 1;
    end
    sequence s_busy_hold;
        busy [*8];
    endsequence
    sequence s_busy_end;
        busy_run_q < MAX_BUSY;
    endsequence
    a_busy_holds: assert property ($rose(busy) |-> s_busy_hold)
        else $error("busy dropped early");
    a_busy_ends: assert property (busy |-> s_busy_end)
        else $error("busy did not end");
    a_map_quiet: assert property ($changed(map_bits) |-> $past(busy))
        else $error("map changed outside a cycle");
    a_map_gain_erase: assert property (|(map_bits & ~$past(map_bits)) |-> &map_bits)
        else $error("map gained bits without erase");
    a_lock_start: assert property ($rose(busy) |-> !$past(map_locked))
        else $error("map cycle started while locked");
    a_prot_or: assert property (prot_enabled == (sw_prot_q || map_locked))
        else $error("protection state mismatch");
    a_disable_pin: assert property ($fell(sw_prot_q) |-> !$past(map_locked))
        else $error("disable taken with pin low");
    a_idle_deny: assert property (!req.valid |-> !req_allow)
        else $error("allow without request");
    a_open_off: assert property (req.valid && !prot_enabled |-> req_allow)
        else $error("access denied while unprotected");
    a_guard_byte: assert property (req.valid && prot_enabled && req.sector != 4'h0
        && map_bits[req.sector*8 +: 8] == SFSP_BYTE_PROT |-> !req_allow)
        else $error("guarded sector allowed");
endmodule // sfsp_protect_properties
`default_nettype wire

/* File: verification/sfsp_host_model.sv */
// SPI host model driving select, serial clock and data
`default_nettype none
module sfsp_host_model
    import sfsp_pkg::*;
(
    input wire logic clk,
    output var sfsp_spi_t spi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    initial
    begin
        spi = 3'b100;
    end
    // Mode 0, MSB first, clock idle low between frames
    task automatic frame();
        logic [7:0] b;
        spi.cs_n <= 1'b0;
        while (q.size() > 0)
        begin
            b = q.pop_front();
            for (int i = 7; i >= 0; i--)
            begin
                spi.si <= b[i];
                repeat (8) @(posedge clk);
                spi.sck <= 1'b1;
                repeat (8) @(posedge clk);
                spi.sck <= 1'b0;
            end
        end
        repeat (8) @(posedge clk);
        spi.cs_n <= 1'b1;
        // Released data line shows the inverse of its last value
        spi.si <= ~spi.si;
    endtask
endmodule // sfsp_host_model
`default_nettype wire

/* File: verification/sfsp_protect_tb.sv */
// Testbench of the sector protection block
`default_nettype none
module sfsp_protect_tb
    import sfsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ERASE_N = 20;
    localparam int PROG_N = 10;
    logic clk;
    logic reset;
    logic wp_n;
    sfsp_spi_t spi;
    sfsp_req_t req;
    logic req_allow;
    logic busy;
    logic prot_enabled;
    logic sw_prot_q;
    logic map_locked;
    logic [127:0] map_bits;
    logic [127:0] exp;
    logic [7:0] pay[$];
    int num_errors = 0;
    int n_checks = 0;
    sfsp_protect #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N), .FILT_CYC(4)) dut (
        .clk(clk), .reset(reset), .spi(spi), .wp_n(wp_n), .req(req),
        .req_allow(req_allow), .busy(busy), .prot_enabled(prot_enabled),
        .sw_prot_q(sw_prot_q), .map_locked(map_locked), .map_bits(map_bits));
    sfsp_host_model host (.clk(clk), .spi(spi));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [127:0] e, input logic [127:0] got);
        n_checks++;
        if (got !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        host.q = {SFSP_PRE0, SFSP_PRE1, SFSP_PRE2, op, pay};
        pay.delete();
        host.frame();
    endtask
    task automatic run_busy(input int e);
        int n = 0;
        for (int i = 0; i < 20 && busy !== 1'b1; i++)
            tick(1);
        while (busy === 1'b1 && n < 5000)
        begin
            tick(1);
            n++;
        end
        chk("busy length", e, n);
    endtask
    task automatic probe(input logic [3:0] s, input logic [7:0] p, input logic e);
        req <= '{1'b1, s, p};
        tick(2);
        chk("access allowed", e, req_allow);
    endtask
    task automatic t_reset();
        chk("reset map", '0, map_bits);
        chk("reset flags", 4'h0, {busy, sw_prot_q, prot_enabled, map_locked});
        probe(4'h5, 8'h00, 1'b1);
    endtask
    task automatic t_pin();
        wp_n <= 1'b0;
        tick(2);
        wp_n <= 1'b1;
        tick(12);
        chk("glitch", 2'b00, {map_locked, prot_enabled});
        wp_n <= 1'b0;
        tick(16);
        chk("pin low", 2'b11, {map_locked, prot_enabled});
        wp_n <= 1'b1;
        tick(16);
        chk("pin released", 2'b00, {map_locked, prot_enabled});
        wp_n <= 1'b0;
        tick(16);
        cmd(SFSP_OP_ERASE);
        run_busy(0);
        chk("locked map", '0, map_bits);
        cmd(SFSP_OP_ENABLE);
        tick(10);
        chk("enable pin low", 1'b1, sw_prot_q);
        cmd(SFSP_OP_DISABLE);
        tick(10);
        chk("disable pin low", 1'b1, sw_prot_q);
        wp_n <= 1'b1;
        tick(16);
        chk("kept after release", 2'b01, {map_locked, prot_enabled});
        cmd(SFSP_OP_DISABLE);
        tick(10);
        chk("disable pin high", 2'b00, {sw_prot_q, prot_enabled});
    endtask
    task automatic t_erase();
        cmd(SFSP_OP_ENABLE);
        tick(10);
        chk("enable", 1'b1, sw_prot_q);
        cmd(SFSP_OP_ERASE);
        run_busy(ERASE_N);
        chk("erased map", {16{SFSP_BYTE_PROT}}, map_bits);
        probe(4'h3, 8'h00, 1'b0);
    endtask
    task automatic t_prog();
        for (int i = 0; i < 17; i++)
            pay.push_back(i == 0 ? 8'h0f : i == 2 ? 8'h00 : i == 16 ? 8'h30 : 8'hff);
        exp = {16{8'hff}};
        exp[23:16] = 8'h00;
        exp[7:0] = 8'h30;
        cmd(SFSP_OP_PROG);
        run_busy(PROG_N);
        chk("programmed map", exp, map_bits);
        probe(4'h0, 8'h07, 1'b1);
        probe(4'h0, 8'h08, 1'b0);
        probe(4'h2, 8'h00, 1'b1);
        probe(4'hf, 8'h00, 1'b0);
        req <= '0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #400000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        reset = 1'b1;
        wp_n = 1'b1;
        req = '0;
        tick(2);
        reset <= 1'b0;
        tick(5);
        t_reset();
        t_pin();
        t_erase();
        t_prog();
        end_of_test();
    end
endmodule // sfsp_protect_tb
bind sfsp_protect sfsp_protect_properties #(.ERASE_CYC(ERASE_CYC)) u_props (
    .clk(clk), .reset(reset), .req(req), .req_allow(req_allow), .busy(busy),
    .prot_enabled(prot_enabled), .sw_prot_q(sw_prot_q), .map_locked(map_locked),
    .map_bits(map_bits));
`default_nettype wire
